/* File: design/sbps_pkg.sv */
// constants and carrier types for the back-tack and presser sequencer
package sbps_pkg;
   // register byte offsets
   localparam logic [7:0] OFS_CFG   = 8'h00;
   localparam logic [7:0] OFS_BTIME = 8'h04;
   localparam logic [7:0] OFS_REVN  = 8'h08;
   localparam logic [7:0] OFS_TRSPD = 8'h0C;
   localparam logic [7:0] OFS_OSSPD = 8'h10;
   localparam logic [7:0] OFS_OSN   = 8'h14;
   localparam logic [7:0] OFS_HOLD  = 8'h18;
   localparam logic [7:0] OFS_STAT  = 8'h1C;
   // config field positions
   localparam int CFG_TRIM_GUARD = 0;
   localparam int CFG_REV_MODE   = 1;
   localparam int CFG_STOP_OK    = 2;
   localparam int CFG_TRIM_AFTER = 3;
   localparam int CFG_PNEUMATIC  = 4;
   localparam int CFG_W          = 5;
   // ranges and reset values
   localparam logic [15:0] BT_MS_MIN   = 16'h0032;
   localparam logic [15:0] BT_MS_MAX   = 16'h01F4;
   localparam logic [15:0] BT_MS_STEP  = 16'h000A;
   localparam logic [15:0] BT_MS_RST   = 16'h00FA;
   localparam logic [15:0] REVN_MAX    = 16'h0013;
   localparam logic [15:0] REVN_RST    = 16'h0004;
   localparam logic [15:0] TRS_MIN     = 16'h0064;
   localparam logic [15:0] TRS_MAX     = 16'h00FA;
   localparam logic [15:0] OSS_MIN     = 16'h0096;
   localparam logic [15:0] OSS_STEP    = 16'h0032;
   localparam logic [15:0] OSS_RST     = 16'h09C4;
   localparam logic [15:0] OSN_RST     = 16'h0010;
   localparam logic [15:0] HOLD_S_MIN  = 16'h000A;
   localparam logic [15:0] HOLD_S_MAX  = 16'h0258;
   localparam logic [15:0] HOLD_S_STEP = 16'h000A;
   localparam logic [15:0] HOLD_S_RST  = 16'h003C;
   localparam logic [CFG_W-1:0] CFG_RST = 5'h00;
   // timing
   localparam int CLK_HZ     = 100_000_000;
   localparam int TICK_MS    = 1;
   localparam int TICK_CYC   = CLK_HZ / 1000 * TICK_MS;
   localparam int MS_PER_SEC = 1000;
   // sequencer states, gray along idle-rev-trim
   typedef enum logic [1:0] {
      SB_IDLE = 2'b00,
      SB_REV  = 2'b01,
      SB_TRIM = 2'b11,
      SB_OS   = 2'b10
   } sbps_state_t;
   typedef struct packed {
      logic pedal_front;
      logic pedal_back;
      logic touch_back;
      logic needle_down;
      logic stitch;
      logic material_end;
      logic os_start;
      logic presser_sw;
      logic poweron_lift;
   } sbps_in_t;
   typedef struct packed {
      logic bt_sol;
      logic trim;
      logic presser_up;
      logic oneshot;
   } sbps_act_t;
endpackage : sbps_pkg

/* File: design/sbps_top.sv */
// back-tack, mid-seam reverse, trim speed and presser lift sequencer
// Behaviour
// - trim guard blocks back-pedal trim when needle lost
// - back-tack solenoid on-time 50..500 ms, 10 ms
// - mode bit picks normal back-tack or reverse
// - reverse runs exactly configured stitches, 0..19
// - stop setting 0 accepts reverse only running
// - stop setting 1 also accepts while stopped
// - reverse accepted while machine running, from idle state only
// - trim-after setting trims after reverse stitches
// - mode 0 ignores stop and trim-after settings
// - trimming speed from setting 100..250 rpm
// - one-shot runs at speed until count/end
// - one-shot speed capped at head maximum
// - power-on lift setting raises presser at start
// - solenoid lifter lowers after 10..600 s hold
// - pneumatic lifter holds up without limit
//
// The APB slave port and the placing of the registers were decided locally.
`timescale 1ns/1ns
module sbps_top #(
   parameter int          TICK_CYC     = sbps_pkg::TICK_CYC,
   parameter logic [15:0] HEAD_MAX_RPM = 16'h0FA0
) (
   // clock and reset
   input  wire logic               pclk,
   input  wire logic               presetn,
   // apb slave
   input  wire logic               psel,
   input  wire logic               penable,
   input  wire logic               pwrite,
   input  wire logic [7:0]         paddr,
   input  wire logic [31:0]        pwdata,
   output logic      [31:0]        prdata,
   output logic                    pready,
   output logic                    pslverr,
   // operator and head pins
   input  wire sbps_pkg::sbps_in_t pins,
   // actuators and motor
   output sbps_pkg::sbps_act_t     act,
   output logic      [15:0]        speed_cmd
);
   import sbps_pkg::*;

   function automatic logic [15:0] clamp(input logic [15:0] v, input logic [15:0] lo,
                                         input logic [15:0] hi, input logic [15:0] st);
      logic [15:0] r;
      r = (v < lo) ? lo : ((v > hi) ? hi : v);
      r = r - ((r - lo) % st);
      return r;
   endfunction : clamp

   // two-flop sync, third stage for edges
   sbps_in_t s1_r, s2_r, s3_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s1_r <= '0;
         s2_r <= '0;
         s3_r <= '0;
      end else begin
         s1_r <= pins;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end
   logic running, tb_rise, back_rise, st_rise, os_rise, pr_rise, nd_fall;
   assign running   = s2_r.pedal_front;
   assign tb_rise   = s2_r.touch_back & ~s3_r.touch_back;
   assign back_rise = s2_r.pedal_back & ~s3_r.pedal_back;
   assign st_rise   = s2_r.stitch & ~s3_r.stitch;
   assign os_rise   = s2_r.os_start & ~s3_r.os_start;
   assign pr_rise   = s2_r.presser_sw & ~s3_r.presser_sw;
   assign nd_fall   = s3_r.needle_down & ~s2_r.needle_down;

   // settings
   logic [CFG_W-1:0] cfg_r;
   logic [15:0]      bt_ms_r, revn_r, trs_r, oss_r, osn_r, hold_r;
   logic             wr_en, rd_en;
   assign wr_en = psel & penable & pready & pwrite;
   assign rd_en = psel & penable & ~pready;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_r   <= CFG_RST;
         bt_ms_r <= BT_MS_RST;
         revn_r  <= REVN_RST;
         trs_r   <= TRS_MIN;
         oss_r   <= OSS_RST;
         osn_r   <= OSN_RST;
         hold_r  <= HOLD_S_RST;
      end else if (wr_en) begin
         case (paddr)
            OFS_CFG:   cfg_r   <= pwdata[CFG_W-1:0];
            OFS_BTIME: bt_ms_r <= clamp(pwdata[15:0], BT_MS_MIN, BT_MS_MAX, BT_MS_STEP);
            OFS_REVN:  revn_r  <= clamp(pwdata[15:0], 16'h0000, REVN_MAX, 16'h0001);
            OFS_TRSPD: trs_r   <= clamp(pwdata[15:0], TRS_MIN, TRS_MAX, 16'h0001);
            OFS_OSSPD: oss_r   <= clamp(pwdata[15:0], OSS_MIN, HEAD_MAX_RPM, OSS_STEP);
            OFS_OSN:   osn_r   <= {8'h00, pwdata[7:0]};
            OFS_HOLD:  hold_r  <= clamp(pwdata[15:0], HOLD_S_MIN, HOLD_S_MAX, HOLD_S_STEP);
            default:   ;
         endcase
      end
   end

   // millisecond and second ticks
   logic [31:0] pre_r;
   logic [9:0]  ms_r;
   logic        ms_tick, s_tick;
   assign ms_tick = (pre_r == 32'(TICK_CYC - 1));
   assign s_tick  = ms_tick & (ms_r == 10'(MS_PER_SEC - 1));
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pre_r <= '0;
         ms_r  <= '0;
      end else begin
         pre_r <= ms_tick ? 32'h00000000 : pre_r + 32'h00000001;
         if (ms_tick) begin
            ms_r <= (ms_r == 10'(MS_PER_SEC - 1)) ? 10'h000 : ms_r + 10'h001;
         end
      end
   end

   // needle-lower position lost by handwheel while stopped
   logic lost_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lost_r <= 1'b0;
      end else if (nd_fall & ~running) begin
         lost_r <= 1'b1;
      end else if (running) begin
         lost_r <= 1'b0;
      end
   end

   // sequencer
   sbps_state_t st_r;
   logic [15:0] cnt_r, lim_r;
   logic        trim_aft_r, bt_req, bt_on_r;
   logic        rev_ok, trim_req, os_end;
   assign rev_ok   = running | cfg_r[CFG_STOP_OK];
   assign trim_req = back_rise & ~(cfg_r[CFG_TRIM_GUARD] & lost_r);
   assign os_end   = s2_r.material_end | (st_rise & (cnt_r + 16'h0001 >= lim_r));

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r       <= SB_IDLE;
         cnt_r      <= '0;
         lim_r      <= '0;
         trim_aft_r <= 1'b0;
      end else begin
         case (st_r)
            SB_IDLE: begin
               cnt_r <= '0;
               if (cfg_r[CFG_REV_MODE] & tb_rise & rev_ok) begin
                  lim_r      <= revn_r;
                  trim_aft_r <= cfg_r[CFG_TRIM_AFTER];
                  st_r       <= (revn_r == 16'h0000) ?
                                (cfg_r[CFG_TRIM_AFTER] ? SB_TRIM : SB_IDLE) : SB_REV;
               end else if (trim_req) begin
                  st_r <= SB_TRIM;
               end else if (os_rise) begin
                  lim_r <= osn_r;
                  st_r  <= (osn_r == 16'h0000) ? SB_IDLE : SB_OS;
               end
            end
            SB_REV: begin
               if (st_rise) begin
                  cnt_r <= cnt_r + 16'h0001;
                  if (cnt_r + 16'h0001 >= lim_r) begin
                     cnt_r <= '0;
                     st_r  <= trim_aft_r ? SB_TRIM : SB_IDLE;
                  end
               end
            end
            SB_TRIM: begin
               if (st_rise) begin
                  st_r <= SB_IDLE;
               end
            end
            SB_OS: begin
               if (st_rise) begin
                  cnt_r <= cnt_r + 16'h0001;
               end
               if (os_end) begin
                  st_r <= SB_IDLE;
               end
            end
            default: st_r <= SB_IDLE;
         endcase
      end
   end

   // back-tack solenoid with on-time limit
   logic [15:0] bt_ms_cnt_r;
   assign bt_req = (st_r == SB_REV) |
                   (~cfg_r[CFG_REV_MODE] & s2_r.touch_back);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         bt_on_r     <= 1'b0;
         bt_ms_cnt_r <= '0;
      end else if (!bt_req) begin
         bt_on_r     <= 1'b0;
         bt_ms_cnt_r <= '0;
      end else if (!bt_on_r && bt_ms_cnt_r == 16'h0000) begin
         bt_on_r <= 1'b1;
      end else if (bt_on_r && ms_tick) begin
         bt_ms_cnt_r <= bt_ms_cnt_r + 16'h0001;
         if (bt_ms_cnt_r + 16'h0001 >= bt_ms_r) begin
            bt_on_r <= 1'b0;
         end
      end
   end

   // presser lift and hold timer
   logic        up_r;
   logic [1:0]  pwr_cnt_r;
   logic [15:0] hold_cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         up_r       <= 1'b0;
         pwr_cnt_r  <= 2'h0;
         hold_cnt_r <= '0;
      end else begin
         // strap read only once the synchroniser holds the pin, not its reset value
         if (pwr_cnt_r != 2'h3) begin
            pwr_cnt_r <= pwr_cnt_r + 2'h1;
         end
         if (pwr_cnt_r != 2'h3) begin
            if (pwr_cnt_r == 2'h2) begin
               up_r <= s2_r.poweron_lift;
            end
            hold_cnt_r <= '0;
         end else if (pr_rise) begin
            up_r       <= 1'b1;
            hold_cnt_r <= '0;
         end else if (running) begin
            up_r <= 1'b0;
         end else if (up_r && !cfg_r[CFG_PNEUMATIC] && s_tick) begin
            hold_cnt_r <= hold_cnt_r + 16'h0001;
            if (hold_cnt_r + 16'h0001 >= hold_r) begin
               up_r <= 1'b0;
            end
         end
      end
   end

   // actuator and speed outputs, all registered
   logic [15:0] os_spd;
   assign os_spd = (oss_r > HEAD_MAX_RPM) ? HEAD_MAX_RPM : oss_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act       <= '0;
         speed_cmd <= '0;
      end else begin
         act.bt_sol     <= bt_on_r;
         act.trim       <= (st_r == SB_TRIM);
         act.presser_up <= up_r;
         act.oneshot    <= (st_r == SB_OS);
         case (st_r)
            SB_TRIM: speed_cmd <= trs_r;
            SB_OS:   speed_cmd <= os_spd;
            default: speed_cmd <= '0;
         endcase
      end
   end

   // apb answer: one wait state, unmapped flags error
   logic mapped;
   assign mapped = (paddr[1:0] == 2'b00) && (paddr <= OFS_STAT);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= '0;
      end else begin
         pready  <= rd_en;
         pslverr <= rd_en & ~mapped;
         if (rd_en && !pwrite) begin
            case (paddr)
               OFS_CFG:   prdata <= {27'h0000000, cfg_r};
               OFS_BTIME: prdata <= {16'h0000, bt_ms_r};
               OFS_REVN:  prdata <= {16'h0000, revn_r};
               OFS_TRSPD: prdata <= {16'h0000, trs_r};
               OFS_OSSPD: prdata <= {16'h0000, oss_r};
               OFS_OSN:   prdata <= {16'h0000, osn_r};
               OFS_HOLD:  prdata <= {16'h0000, hold_r};
               OFS_STAT:  prdata <= {cnt_r[7:0], 16'h0000, 2'b00, lost_r, up_r,
                                     bt_on_r, 1'b0, st_r};
               default:   prdata <= '0;
            endcase
         end else begin
            prdata <= '0;
         end
      end
   end
endmodule : sbps_top

/* File: verification/sbps_head_model.sv */
// head and drive model: stitch sensor and needle sensor
`timescale 1ns/1ns
module sbps_head_model #(
   parameter int PERIOD = 40
) (
   // clock and reset
   input  wire logic pclk,
   input  wire logic presetn,
   // drive and handwheel
   input  wire logic run_en,
   input  wire logic hand,
   // sensors
   output logic      stitch,
   output logic      needle_down
);
   int cnt_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) cnt_r <= 0;
      else if (run_en) cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
   end
   // a standing shaft gives no stitch edges
   assign stitch      = run_en && (cnt_r < PERIOD / 2);
   assign needle_down = !hand;
endmodule : sbps_head_model

/* File: verification/sbps_properties.sv */
// port checks for the sequencer
`timescale 1ns/1ns
module sbps_properties
   import sbps_pkg::*;
#(
   parameter int          TICK_CYC     = 10,
   parameter logic [15:0] HEAD_MAX_RPM = 16'h0FA0
) (
   // clock, reset, apb
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   // pins and outputs
   input wire sbps_in_t    pins,
   input wire sbps_act_t   act,
   input wire logic [15:0] speed_cmd
);
   int bt_n_r;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // length of the current solenoid drive, one tick of slack for phase
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) bt_n_r <= 0;
      else bt_n_r <= act.bt_sol ? bt_n_r + 1 : 0;
   end
   chk_apb_wait: assert property ($rose(psel && penable) |=> pready)
      else $error("ready late");
   chk_ready_pulse: assert property (pready |=> !pready)
      else $error("ready held");
   chk_err_map: assert property (pready |-> pslverr == (paddr > 8'h1C || paddr[1:0] != 2'b00))
      else $error("error flag wrong");
   chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
      else $error("read data outside answer");
   chk_speed_idle: assert property (!act.trim && !act.oneshot |-> speed_cmd == 16'h0000)
      else $error("speed while idle");
   chk_trim_speed: assert property (act.trim |-> speed_cmd >= TRS_MIN && speed_cmd <= TRS_MAX)
      else $error("trim speed out of range");
   chk_os_cap: assert property (act.oneshot && !act.trim |-> speed_cmd <= HEAD_MAX_RPM)
      else $error("one-shot speed over cap");
   chk_bt_limit: assert property (bt_n_r <= 500 * TICK_CYC + TICK_CYC + 2)
      else $error("solenoid on too long");
   chk_bt_cause: assert property ($rose(act.bt_sol) |-> $past(pins.touch_back, 3)
      || $past(pins.touch_back, 4) || $past(pins.touch_back, 5)) else $error("solenoid w/o switch");
endmodule : sbps_properties

bind sbps_top sbps_properties #(.TICK_CYC(TICK_CYC), .HEAD_MAX_RPM(HEAD_MAX_RPM)) chk_u (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins), .act(act),
   .speed_cmd(speed_cmd));

/* File: verification/sbps_tb_top.sv */
// self-checking bench for the sequencer
`timescale 1ns/1ns
module sbps_tb_top;
   import sbps_pkg::*;
   localparam logic [15:0] HMAX = 16'h0FA0;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, e, run_en, hand;
   logic        stitch_w, needle_w;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic [15:0] speed_cmd;
   sbps_in_t    op, pins_w;
   sbps_act_t   act;
   int          mismatches, cmp_count, cyc;
   assign pins_w = {op[8:6], needle_w, stitch_w, op[3:0]};
   sbps_top #(.TICK_CYC(10), .HEAD_MAX_RPM(HMAX)) dut_u (.pclk(pclk), .presetn(presetn),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pins(pins_w), .act(act),
      .speed_cmd(speed_cmd));
   sbps_head_model head_u (.pclk(pclk), .presetn(presetn), .run_en(run_en), .hand(hand),
      .stitch(stitch_w), .needle_down(needle_w));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask : end_sim
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         mismatches++;
         end_sim();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   // request held until pready is seen high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      for (int n = 0; n < 20; n++) begin
         @(posedge pclk);
         if (pready === 1'b1) break;
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x);
      apb(1'b0, a, 32'h0);
      chk(q, x);
   endtask : rd_chk
   task automatic rd_st(input logic [1:0] s);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(q[1:0], s);
   endtask : rd_st
   task automatic wait_act(input int i, input logic v);
      for (int n = 0; n < 100; n++) begin
         @(posedge pclk);
         if (act[i] === v) break;
      end
   endtask : wait_act
   task automatic t_regs;
      logic [7:0]  ta [7] = '{OFS_BTIME, OFS_BTIME, OFS_REVN, OFS_TRSPD, OFS_OSSPD, OFS_HOLD,
                              OFS_BTIME};
      logic [15:0] tw [7] = '{16'h03E8, 16'h0007, 16'h0019, 16'h00C8, 16'h00AF, 16'h025D,
                              16'h0039};
      logic [15:0] te [7] = '{16'h01F4, 16'h0032, 16'h0013, 16'h00C8, 16'h0096, 16'h0258,
                              16'h0032};
      rd_chk(OFS_BTIME, 32'h000000FA);
      rd_chk(OFS_REVN, 32'h00000004);
      rd_chk(OFS_OSSPD, 32'h000009C4);
      rd_chk(OFS_HOLD, 32'h0000003C);
      for (int i = 0; i < 7; i++) begin
         apb(1'b1, ta[i], {16'h0, tw[i]});
         rd_chk(ta[i], {16'h0, te[i]});
      end
      rd_chk(8'h20, 32'h0);
      chk(e, 1'b1);
      apb(1'b1, OFS_REVN, 32'h3);
      $display("registers done");
   endtask : t_regs
   task automatic t_backtack;
      apb(1'b1, OFS_CFG, 32'h0000000C);
      op.touch_back <= 1'b1;
      wait_act(3, 1'b1);
      chk(act.bt_sol, 1'b1);
      rd_st(2'b00);
      repeat (440) @(posedge pclk);
      chk(act.bt_sol, 1'b1);
      repeat (120) @(posedge pclk);
      chk(act.bt_sol, 1'b0);
      op.touch_back <= 1'b0;
      $display("back-tack done");
   endtask : t_backtack
   task automatic t_reverse(input logic tr);
      int  n;
      logic p;
      apb(1'b1, OFS_CFG, {28'h0, tr, 3'b010});
      op.pedal_front <= 1'b1;
      op.touch_back <= 1'b1;
      wait_act(3, 1'b1);
      chk(act.bt_sol, 1'b1);
      n = 0;
      p = 1'b0;
      run_en <= 1'b1;
      repeat (240) begin
         @(posedge pclk);
         if (act.trim === 1'b1) break;
         if (stitch_w && !p) n++;
         p = stitch_w;
      end
      chk(act.trim, tr);
      if (tr) chk(n, 3);
      if (tr) chk(speed_cmd, 16'h00C8);
      repeat (60) @(posedge pclk);
      run_en <= 1'b0;
      op.touch_back <= 1'b0;
      op.pedal_front <= 1'b0;
      rd_st(2'b00);
      $display("reverse done");
   endtask : t_reverse
   task automatic t_stop;
      apb(1'b1, OFS_CFG, 32'h2);
      op.touch_back <= 1'b1;
      repeat (20) @(posedge pclk);
      rd_st(2'b00);
      op.touch_back <= 1'b0;
      apb(1'b1, OFS_CFG, 32'h6);
      op.touch_back <= 1'b1;
      repeat (20) @(posedge pclk);
      rd_st(2'b01);
      run_en <= 1'b1;
      repeat (160) @(posedge pclk);
      run_en <= 1'b0;
      op.touch_back <= 1'b0;
      rd_st(2'b00);
      $display("stop condition done");
   endtask : t_stop
   task automatic t_trim;
      apb(1'b1, OFS_CFG, 32'h1);
      hand <= 1'b1;
      repeat (10) @(posedge pclk);
      op.pedal_back <= 1'b1;
      repeat (20) @(posedge pclk);
      chk(act.trim, 1'b0);
      op.pedal_back <= 1'b0;
      apb(1'b1, OFS_CFG, 32'h0);
      op.pedal_back <= 1'b1;
      wait_act(2, 1'b1);
      chk(speed_cmd, 16'h00C8);
      op.pedal_back <= 1'b0;
      hand <= 1'b0;
      run_en <= 1'b1;
      wait_act(2, 1'b0);
      run_en <= 1'b0;
      apb(1'b1, OFS_OSSPD, 32'h0000FFFF);
      op.os_start <= 1'b1;
      wait_act(0, 1'b1);
      chk(speed_cmd, HMAX);
      op.material_end <= 1'b1;
      wait_act(0, 1'b0);
      chk(act.oneshot, 1'b0);
      $display("trim and one-shot done");
   endtask : t_trim
   initial begin
      mismatches = 0;
      cmp_count = 0;
      cyc = 0;
      presetn = 1'b0;
      {psel, penable, pwrite, paddr, pwdata, run_en, hand} = '0;
      op = 9'h001;
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      repeat (10) @(posedge pclk);
      chk(act.presser_up, 1'b1);
      t_regs();
      t_backtack();
      t_reverse(1'b1);
      t_reverse(1'b0);
      t_stop();
      t_trim();
      end_sim();
   end
endmodule : sbps_tb_top
